//--- ttr_rx_status_regs.v
// Trail trace receive status registers with APB slave and identifier windows
//
// The APB interface to the registers and the address map are this design's own decisions.
`timescale 1ns/100ps
`include "ttr_consts.vh"

// Summary of operation
// - Idle after five consecutive all-zero identifiers
// - Change flag sets when stored identifier updates
// - Mismatch flag sets on live mismatch rise
// - Unstable flag sets on live unstable rise
// - Idle flag sets on live idle rise
// - Each latched flag has own interrupt enable
// - Interrupt also needs port summary enable
// - Received byte register returns addressed stored byte
// - Each received byte read advances, wraps
// - Expected byte register reads, writes addressed byte
// - Each expected byte access advances, wraps
// - Live mismatch high while identifiers differ
// - Unstable after eight unmatched identifiers in row
// - Two four-bit address fields, reset zero
module ttr_rx_status_regs
(
  input  wire                        clk_sys_i,
  input  wire                        reset_i,
  input  wire [`TTR_PADDR_W-1:0]     paddr_i,
  input  wire                        psel_i,
  input  wire                        penable_i,
  input  wire                        pwrite_i,
  input  wire [31:0]                 pwdata_i,
  output reg  [31:0]                 prdata_o,
  output wire                        pready_o,
  output wire                        pslverr_o,
  input  wire [`TTR_BYTE_W-1:0]      id_byte_i,
  input  wire                        id_byte_valid_i,
  input  wire                        id_byte_first_i,
  input  wire                        port_summary_irq_en_i,
  output wire                        irq_o
);

  // Register selects
  wire                       apb_setup;
  wire                       apb_access;
  wire                       sel_id_addr;
  wire                       sel_live;
  wire                       sel_latched;
  wire                       sel_irq_en;
  wire                       sel_rx_byte;
  wire                       sel_exp_byte;
  wire                       sel_any;
  wire                       wr_access;
  wire                       rd_access;
  wire                       wr_id_addr;
  wire                       wr_latched;
  wire                       wr_irq_en;
  wire                       wr_exp_byte;
  wire                       rd_rx_byte;
  wire                       acc_exp_byte;

  // Register state
  reg  [`TTR_EV_W-1:0]       rx_latched;
  reg  [`TTR_EV_W-1:0]       irq_en;
  reg  [`TTR_IDA_W-1:0]      rx_id_addr;
  reg  [`TTR_IDA_W-1:0]      expected_id_addr;
  reg  [`TTR_BYTE_W-1:0]     expected_id_mem [0:`TTR_ID_BYTES-1];
  reg                        rx_id_mismatch;
  reg  [`TTR_EV_W-1:0]       live_prev;

  // Combinational terms
  reg  [`TTR_EV_W-1:0]       next_rx_latched;
  reg  [31:0]                next_prdata;
  reg  [`TTR_ID_BITS-1:0]    expected_flat;
  wire [`TTR_EV_W-1:0]       live_status;
  wire [`TTR_EV_W-1:0]       live_rise;
  wire [`TTR_EV_W-1:0]       latch_set;
  wire [`TTR_EV_W-1:0]       latch_clr;
  wire [`TTR_BYTE_W-1:0]     rx_id_byte;
  wire [`TTR_ID_BITS-1:0]    stored_id;
  wire                       rx_id_idle;
  wire                       rx_id_unstable;
  wire                       rx_id_change;
  integer                    i;
  integer                    j;

  // Interrupt path
  wire [`TTR_EV_W-1:0]       irq_src;
  wire                       next_irq;
  reg                        irq_q;

  // Byte address of a register index
  function [`TTR_PADDR_W-1:0] reg_addr;
    input [`TTR_PADDR_W-1:0] idx;
    begin
      reg_addr = {idx[`TTR_PADDR_W-1-`TTR_IDX_SHIFT:0], {`TTR_IDX_SHIFT{1'b0}}};
    end
  endfunction

  // Identifier address step with wrap from last byte to first
  function [`TTR_IDA_W-1:0] ida_next;
    input [`TTR_IDA_W-1:0] a;
    begin
      if (a == `TTR_IDA_LAST)
      begin
        ida_next = `TTR_IDA_FIRST;
      end
      else
      begin
        ida_next = a + `TTR_IDA_STEP;
      end
    end
  endfunction

  ttr_id_monitor u_id_monitor
  (
    .clk_sys_i       (clk_sys_i),
    .reset_i         (reset_i),
    .id_byte_i       (id_byte_i),
    .id_byte_valid_i (id_byte_valid_i),
    .id_byte_first_i (id_byte_first_i),
    .rd_index_i      (rx_id_addr),
    .rd_byte_o       (rx_id_byte),
    .stored_id_o     (stored_id),
    .id_idle_o       (rx_id_idle),
    .id_unstable_o   (rx_id_unstable),
    .id_change_o     (rx_id_change)
  );

  // APB decode
  assign apb_setup    = psel_i & ~penable_i;
  assign apb_access   = psel_i & penable_i;
  assign sel_id_addr  = (paddr_i == reg_addr(`TTR_IDX_ID_ADDR));
  assign sel_live     = (paddr_i == reg_addr(`TTR_IDX_LIVE));
  assign sel_latched  = (paddr_i == reg_addr(`TTR_IDX_LATCHED));
  assign sel_irq_en   = (paddr_i == reg_addr(`TTR_IDX_IRQ_EN));
  assign sel_rx_byte  = (paddr_i == reg_addr(`TTR_IDX_RX_BYTE));
  assign sel_exp_byte = (paddr_i == reg_addr(`TTR_IDX_EXP_BYTE));
  assign sel_any      = sel_id_addr | sel_live | sel_latched | sel_irq_en |
                        sel_rx_byte | sel_exp_byte;
  assign wr_access    = apb_access & pwrite_i;
  assign rd_access    = apb_access & ~pwrite_i;
  assign pready_o     = apb_access;
  assign pslverr_o    = apb_access & ~sel_any;

  // Write and read strobes
  assign wr_id_addr   = wr_access & sel_id_addr;
  assign wr_latched   = wr_access & sel_latched;
  assign wr_irq_en    = wr_access & sel_irq_en;
  assign wr_exp_byte  = wr_access & sel_exp_byte;
  assign rd_rx_byte   = rd_access & sel_rx_byte;
  assign acc_exp_byte = apb_access & sel_exp_byte;

  // Read data mux, sampled in the setup cycle
  always @*
  begin
    next_prdata = `TTR_RST_DATA;
    if (sel_id_addr)
    begin
      next_prdata[`TTR_RX_ADDR_LSB +: `TTR_IDA_W]  = rx_id_addr;
      next_prdata[`TTR_EXP_ADDR_LSB +: `TTR_IDA_W] = expected_id_addr;
    end
    else if (sel_live)
    begin
      next_prdata[`TTR_EV_W-1:0] = live_status;
    end
    else if (sel_latched)
    begin
      next_prdata[`TTR_EV_W-1:0] = rx_latched;
    end
    else if (sel_irq_en)
    begin
      next_prdata[`TTR_EV_W-1:0] = irq_en;
    end
    else if (sel_rx_byte)
    begin
      next_prdata[`TTR_BYTE_W-1:0] = rx_id_byte;
    end
    else if (sel_exp_byte)
    begin
      next_prdata[`TTR_BYTE_W-1:0] = expected_id_mem[expected_id_addr];
    end
  end

  always @(posedge clk_sys_i)
  begin
    if (reset_i)
    begin
      prdata_o <= `TTR_RST_DATA;
    end
    else if (apb_setup & ~pwrite_i)
    begin
      prdata_o <= next_prdata;
    end
  end

  // Identifier address fields
  always @(posedge clk_sys_i)
  begin
    if (reset_i)
    begin
      rx_id_addr       <= `TTR_RST_IDA;
      expected_id_addr <= `TTR_RST_IDA;
    end
    else
    begin
      // A write to the address register wins over an increment
      if (wr_id_addr)
      begin
        rx_id_addr       <= pwdata_i[`TTR_RX_ADDR_LSB +: `TTR_IDA_W];
        expected_id_addr <= pwdata_i[`TTR_EXP_ADDR_LSB +: `TTR_IDA_W];
      end
      else
      begin
        if (rd_rx_byte)
        begin
          rx_id_addr <= ida_next(rx_id_addr);
        end
        if (acc_exp_byte)
        begin
          expected_id_addr <= ida_next(expected_id_addr);
        end
      end
    end
  end

  // Expected identifier memory
  always @(posedge clk_sys_i)
  begin
    if (reset_i)
    begin
      for (i = 0; i < `TTR_ID_BYTES; i = i + 1)
      begin
        expected_id_mem[i] <= `TTR_RST_BYTE;
      end
    end
    else if (wr_exp_byte)
    begin
      expected_id_mem[expected_id_addr] <= pwdata_i[`TTR_BYTE_W-1:0];
    end
  end

  // Expected identifier as a vector, byte 0 on top
  always @*
  begin
    expected_flat = {`TTR_ID_BITS{1'b0}};
    for (j = 0; j < `TTR_ID_BYTES; j = j + 1)
    begin
      expected_flat[(`TTR_ID_BYTES-1-j)*`TTR_BYTE_W +: `TTR_BYTE_W] = expected_id_mem[j];
    end
  end

  // Live mismatch
  always @(posedge clk_sys_i)
  begin
    if (reset_i)
    begin
      rx_id_mismatch <= 1'b0;
    end
    else
    begin
      rx_id_mismatch <= (stored_id != expected_flat);
    end
  end

  assign live_status[`TTR_BIT_IDLE]     = rx_id_idle;
  assign live_status[`TTR_BIT_UNSTABLE] = rx_id_unstable;
  assign live_status[`TTR_BIT_MISMATCH] = rx_id_mismatch;
  assign live_status[`TTR_BIT_CHANGE]   = 1'b0;

  // Rising edge detection of live status
  // Cleared to the idle level so no false edge follows reset
  always @(posedge clk_sys_i)
  begin
    if (reset_i)
    begin
      live_prev <= `TTR_RST_EV;
    end
    else
    begin
      live_prev <= live_status;
    end
  end

  assign live_rise = live_status & ~live_prev;

  assign latch_set[`TTR_BIT_IDLE]     = live_rise[`TTR_BIT_IDLE];
  assign latch_set[`TTR_BIT_UNSTABLE] = live_rise[`TTR_BIT_UNSTABLE];
  assign latch_set[`TTR_BIT_MISMATCH] = live_rise[`TTR_BIT_MISMATCH];
  assign latch_set[`TTR_BIT_CHANGE]   = rx_id_change;

  assign latch_clr = wr_latched ? pwdata_i[`TTR_EV_W-1:0] : `TTR_RST_EV;

  // Latched flags: write one clears, a new event wins
  always @*
  begin
    next_rx_latched = (rx_latched & ~latch_clr) | latch_set;
  end

  always @(posedge clk_sys_i)
  begin
    if (reset_i)
    begin
      rx_latched <= `TTR_RST_EV;
    end
    else
    begin
      rx_latched <= next_rx_latched;
    end
  end

  // Interrupt enables
  always @(posedge clk_sys_i)
  begin
    if (reset_i)
    begin
      irq_en <= `TTR_RST_EV;
    end
    else if (wr_irq_en)
    begin
      irq_en <= pwdata_i[`TTR_EV_W-1:0];
    end
  end

  // Per-event sources gated by their enables
  assign irq_src  = rx_latched & irq_en;
  assign next_irq = port_summary_irq_en_i & (|irq_src);

  // Interrupt output from a flip-flop
  always @(posedge clk_sys_i)
  begin
    if (reset_i)
    begin
      irq_q <= 1'b0;
    end
    else
    begin
      irq_q <= next_irq;
    end
  end

  assign irq_o = irq_q;

endmodule // ttr_rx_status_regs

//--- ttr_consts.vh
// Constants for the trail trace receive status register bank
`ifndef TTR_CONSTS_VH
`define TTR_CONSTS_VH

// APB address width and register indices (byte address is four times the index)
`define TTR_PADDR_W        12
`define TTR_IDX_ID_ADDR    12'h0f2
`define TTR_IDX_LIVE       12'h0f4
`define TTR_IDX_LATCHED    12'h0f6
`define TTR_IDX_IRQ_EN     12'h0f8
`define TTR_IDX_RX_BYTE    12'h0fc
`define TTR_IDX_EXP_BYTE   12'h0fe
`define TTR_IDX_SHIFT      2

// Event and status field positions
`define TTR_EV_W           4
`define TTR_BIT_IDLE       0
`define TTR_BIT_UNSTABLE   1
`define TTR_BIT_MISMATCH   2
`define TTR_BIT_CHANGE     3

// Identifier address fields
`define TTR_IDA_W          4
`define TTR_RX_ADDR_LSB    0
`define TTR_EXP_ADDR_LSB   8
`define TTR_IDA_STEP       4'h1
`define TTR_IDA_LAST       4'hf
`define TTR_IDA_FIRST      4'h0

// Identifier geometry
`define TTR_BYTE_W         8
`define TTR_ID_BYTES       16
`define TTR_ID_BITS        128
`define TTR_ID_SHIFT_MSB   119

// Persistence counts
`define TTR_IDLE_CNT_W     3
`define TTR_IDLE_COUNT     3'h5
`define TTR_IDLE_STEP      3'h1
`define TTR_UNST_CNT_W     4
`define TTR_UNST_COUNT     4'h8
`define TTR_UNST_STEP      4'h1

// Reset values
`define TTR_RST_DATA       32'h0000_0000
`define TTR_RST_EV         4'h0
`define TTR_RST_IDA        4'h0
`define TTR_RST_BYTE       8'h00
`define TTR_RST_IDLE_CNT   3'h0
`define TTR_RST_UNST_CNT   4'h0

`endif

//--- ttr_id_monitor.v
// Received identifier capture, idle and unstable detection
`timescale 1ns/100ps
`include "ttr_consts.vh"
module ttr_id_monitor
(
  input  wire                        clk_sys_i,
  input  wire                        reset_i,
  input  wire [`TTR_BYTE_W-1:0]      id_byte_i,
  input  wire                        id_byte_valid_i,
  input  wire                        id_byte_first_i,
  input  wire [`TTR_IDA_W-1:0]       rd_index_i,
  output wire [`TTR_BYTE_W-1:0]      rd_byte_o,
  output wire [`TTR_ID_BITS-1:0]     stored_id_o,
  output reg                         id_idle_o,
  output reg                         id_unstable_o,
  output reg                         id_change_o
);

  reg  [`TTR_IDA_W-1:0]      byte_idx;
  reg  [`TTR_ID_BITS-1:0]    shift_id;
  reg  [`TTR_ID_BITS-1:0]    stored_id;
  reg  [`TTR_ID_BITS-1:0]    cand_id;
  reg  [`TTR_IDLE_CNT_W-1:0] idle_cnt;
  reg  [`TTR_UNST_CNT_W-1:0] unst_cnt;
  wire [`TTR_IDA_W-1:0]      cur_idx;
  wire [`TTR_ID_BITS-1:0]    next_id;
  wire                       id_done;
  wire [`TTR_IDLE_CNT_W-1:0] next_idle_cnt;
  wire [`TTR_UNST_CNT_W-1:0] next_unst_cnt;

  assign cur_idx       = id_byte_first_i ? `TTR_IDA_FIRST : byte_idx;
  assign id_done       = id_byte_valid_i & (cur_idx == `TTR_IDA_LAST);
  assign next_id       = {shift_id[`TTR_ID_SHIFT_MSB:0], id_byte_i};
  assign next_idle_cnt = (idle_cnt == `TTR_IDLE_COUNT) ? idle_cnt : idle_cnt + `TTR_IDLE_STEP;
  assign next_unst_cnt = (unst_cnt == `TTR_UNST_COUNT) ? unst_cnt : unst_cnt + `TTR_UNST_STEP;
  assign stored_id_o   = stored_id;
  // Byte 0 sits in the top byte of the vector
  assign rd_byte_o     = stored_id[(`TTR_ID_BYTES-1-rd_index_i)*`TTR_BYTE_W +: `TTR_BYTE_W];

  always @(posedge clk_sys_i)
  begin
    if (reset_i)
    begin
      byte_idx      <= `TTR_RST_IDA;
      shift_id      <= {`TTR_ID_BITS{1'b0}};
      stored_id     <= {`TTR_ID_BITS{1'b0}};
      cand_id       <= {`TTR_ID_BITS{1'b0}};
      idle_cnt      <= `TTR_RST_IDLE_CNT;
      unst_cnt      <= `TTR_RST_UNST_CNT;
      id_idle_o     <= 1'b0;
      id_unstable_o <= 1'b0;
      id_change_o   <= 1'b0;
    end
    else
    begin
      id_change_o <= 1'b0;
      if (id_byte_valid_i)
      begin
        byte_idx <= cur_idx + `TTR_IDA_STEP;
        shift_id <= next_id;
      end
      if (id_done)
      begin
        if (next_id == {`TTR_ID_BITS{1'b0}})
        begin
          idle_cnt  <= next_idle_cnt;
          id_idle_o <= (next_idle_cnt == `TTR_IDLE_COUNT);
        end
        else
        begin
          idle_cnt  <= `TTR_RST_IDLE_CNT;
          id_idle_o <= 1'b0;
        end
        if (next_id == stored_id)
        begin
          cand_id       <= next_id;
          unst_cnt      <= `TTR_RST_UNST_CNT;
          id_unstable_o <= 1'b0;
        end
        else if (next_id == cand_id)
        begin
          stored_id     <= next_id;
          id_change_o   <= 1'b1;
          unst_cnt      <= `TTR_RST_UNST_CNT;
          id_unstable_o <= 1'b0;
        end
        else
        begin
          cand_id       <= next_id;
          unst_cnt      <= next_unst_cnt;
          id_unstable_o <= (next_unst_cnt == `TTR_UNST_COUNT);
        end
      end
    end
  end

endmodule // ttr_id_monitor

//--- ttr_rx_status_regs_properties.sv
// Port-level assertions for the trail trace receive status registers
`timescale 1ns/100ps
`include "ttr_consts.vh"
module ttr_rx_status_checker
(
  input wire        clk_sys_i,
  input wire        reset_i,
  input wire [11:0] paddr_i,
  input wire        psel_i,
  input wire        penable_i,
  input wire        pwrite_i,
  input wire [31:0] pwdata_i,
  input wire [31:0] prdata_o,
  input wire        pready_o,
  input wire        pslverr_o,
  input wire [7:0]  id_byte_i,
  input wire        id_byte_valid_i,
  input wire        id_byte_first_i,
  input wire        port_summary_irq_en_i,
  input wire        irq_o
);
  localparam [11:0] A_IDA = `TTR_IDX_ID_ADDR << `TTR_IDX_SHIFT;
  localparam [11:0] A_LAT = `TTR_IDX_LATCHED << `TTR_IDX_SHIFT;
  localparam [11:0] A_EN  = `TTR_IDX_IRQ_EN << `TTR_IDX_SHIFT;
  localparam [11:0] A_RXB = `TTR_IDX_RX_BYTE << `TTR_IDX_SHIFT;
  localparam [11:0] A_EXB = `TTR_IDX_EXP_BYTE << `TTR_IDX_SHIFT;
  wire       acc    = psel_i & penable_i;
  wire       rd_acc = acc & ~pwrite_i;
  wire       wr_acc = acc & pwrite_i;
  reg  [3:0] rx_sh;
  reg  [3:0] ex_sh;
  reg  [3:0] en_sh;
  reg  [3:0] lat_sh;

  // Shadow copies of address fields, enables and last seen flags
  always @(posedge clk_sys_i)
    rx_sh <= reset_i ? 4'h0 : (wr_acc && paddr_i == A_IDA) ? pwdata_i[3:0] :
             (rd_acc && paddr_i == A_RXB) ? rx_sh + 4'h1 : rx_sh;
  always @(posedge clk_sys_i)
    ex_sh <= reset_i ? 4'h0 : (wr_acc && paddr_i == A_IDA) ? pwdata_i[11:8] :
             (acc && paddr_i == A_EXB) ? ex_sh + 4'h1 : ex_sh;
  always @(posedge clk_sys_i)
    en_sh <= reset_i ? 4'h0 : (wr_acc && paddr_i == A_EN) ? pwdata_i[3:0] : en_sh;
  always @(posedge clk_sys_i)
    lat_sh <= reset_i ? 4'h0 : (wr_acc && paddr_i == A_LAT) ? lat_sh & ~pwdata_i[3:0] :
              (rd_acc && paddr_i == A_LAT) ? prdata_o[3:0] : lat_sh;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);

  a_addr_track: assert property (
    rd_acc && paddr_i == A_IDA |-> prdata_o[3:0] == rx_sh && prdata_o[11:8] == ex_sh)
    else $error("id address fields off");
  a_flags_sticky: assert property (
    rd_acc && paddr_i == A_LAT |-> (prdata_o[3:0] & lat_sh) == lat_sh)
    else $error("latched flag lost");
  a_irq_gate: assert property (
    !port_summary_irq_en_i |=> !irq_o) else $error("irq without summary enable");
  a_irq_unmasked: assert property (
    en_sh == 4'h0 |=> !irq_o) else $error("irq with enables off");
  a_irq_reset: assert property (
    $fell(reset_i) |-> !irq_o ##1 !irq_o) else $error("irq after reset");
  a_en_readback: assert property (
    rd_acc && paddr_i == A_EN |-> prdata_o == {28'h000_0000, en_sh})
    else $error("enable readback differs");
  a_rx_byte_width: assert property (
    rd_acc && paddr_i == A_RXB |-> prdata_o[31:8] == 24'h00_0000) else $error("rx byte high");
  a_exp_byte_width: assert property (
    rd_acc && paddr_i == A_EXB |-> prdata_o[31:8] == 24'h00_0000) else $error("exp byte high");
  a_ready_access: assert property (
    acc |-> pready_o) else $error("no ready in access phase");
endmodule // ttr_rx_status_checker

bind ttr_rx_status_regs ttr_rx_status_checker u_chk
(
  .clk_sys_i(clk_sys_i),
  .reset_i(reset_i),
  .paddr_i(paddr_i),
  .psel_i(psel_i),
  .penable_i(penable_i),
  .pwrite_i(pwrite_i),
  .pwdata_i(pwdata_i),
  .prdata_o(prdata_o),
  .pready_o(pready_o),
  .pslverr_o(pslverr_o),
  .id_byte_i(id_byte_i),
  .id_byte_valid_i(id_byte_valid_i),
  .id_byte_first_i(id_byte_first_i),
  .port_summary_irq_en_i(port_summary_irq_en_i),
  .irq_o(irq_o)
);

//--- ttr_rx_status_tb.sv
// Self-checking bench for the trail trace receive status registers
`timescale 1ns/100ps
`include "ttr_consts.vh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin err_count++; \
  $display("wrong value at %0t: got %h expected %h", $time, (g), (e)); end end
module testbench;
  localparam [11:0] A_IDA = `TTR_IDX_ID_ADDR << `TTR_IDX_SHIFT;
  localparam [11:0] A_LIV = `TTR_IDX_LIVE << `TTR_IDX_SHIFT;
  localparam [11:0] A_LAT = `TTR_IDX_LATCHED << `TTR_IDX_SHIFT;
  localparam [11:0] A_EN  = `TTR_IDX_IRQ_EN << `TTR_IDX_SHIFT;
  localparam [11:0] A_RXB = `TTR_IDX_RX_BYTE << `TTR_IDX_SHIFT;
  localparam [11:0] A_EXB = `TTR_IDX_EXP_BYTE << `TTR_IDX_SHIFT;
  reg         clk_sys_i, reset_i, psel_i, penable_i, pwrite_i, err;
  reg         id_byte_valid_i, id_byte_first_i, port_summary_irq_en_i;
  reg  [11:0] paddr_i;
  reg  [31:0] pwdata_i, rd;
  reg  [7:0]  id_byte_i;
  wire [31:0] prdata_o;
  wire        pready_o, pslverr_o, irq_o;
  integer     err_count, checked, k;

  ttr_rx_status_regs u_dut
  (
    .clk_sys_i(clk_sys_i),
    .reset_i(reset_i),
    .paddr_i(paddr_i),
    .psel_i(psel_i),
    .penable_i(penable_i),
    .pwrite_i(pwrite_i),
    .pwdata_i(pwdata_i),
    .prdata_o(prdata_o),
    .pready_o(pready_o),
    .pslverr_o(pslverr_o),
    .id_byte_i(id_byte_i),
    .id_byte_valid_i(id_byte_valid_i),
    .id_byte_first_i(id_byte_first_i),
    .port_summary_irq_en_i(port_summary_irq_en_i),
    .irq_o(irq_o)
  );

  initial
  begin
    clk_sys_i = 1'b0;
    forever #10 clk_sys_i = ~clk_sys_i;
  end

  // One APB transfer; read data and error taken at the ready edge
  task apb(input w, input [11:0] a, input [15:0] d);
    integer n;
    begin
      @(posedge clk_sys_i);
      psel_i <= 1'b1;
      paddr_i <= a;
      pwrite_i <= w;
      pwdata_i <= {16'h0000, d};
      @(posedge clk_sys_i);
      penable_i <= 1'b1;
      n = 0;
      @(posedge clk_sys_i);
      while (pready_o !== 1'b1 && n < 50)
      begin
        n = n + 1;
        @(posedge clk_sys_i);
      end
      if (n >= 50)
        err_count++;
      rd = prdata_o;
      err = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
    end
  endtask

  task rdc(input [11:0] a, input [15:0] e);
    begin
      apb(1'b0, a, 16'h0000);
      `CHK(rd, {16'h0000, e})
      `CHK(err, 1'b0)
    end
  endtask

  task irqc(input e);
    begin
      @(posedge clk_sys_i);
      @(negedge clk_sys_i);
      `CHK(irq_o, e)
    end
  endtask

  // Sends one identifier; byte k is b+k, or zero for an idle identifier
  task send_id(input [7:0] b);
    integer i;
    begin
      for (i = 0; i < 16; i++)
      begin
        @(posedge clk_sys_i);
        id_byte_valid_i <= 1'b1;
        id_byte_first_i <= (i == 0);
        id_byte_i <= (b == 8'h00) ? 8'h00 : b + i[7:0];
      end
      @(posedge clk_sys_i);
      id_byte_valid_i <= 1'b0;
      id_byte_first_i <= 1'b0;
      repeat (4) @(posedge clk_sys_i);
    end
  endtask

  task end_of_test;
    begin
      $display("checks %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask

  initial
  begin
    repeat (20000) @(posedge clk_sys_i);
    err_count++;
    end_of_test;
  end

  initial
  begin
    err_count = 0;
    checked = 0;
    {reset_i, psel_i, penable_i, pwrite_i, id_byte_valid_i, id_byte_first_i} = 6'h20;
    port_summary_irq_en_i = 1'b1;
    paddr_i = 12'h000;
    pwdata_i = 32'h0000_0000;
    id_byte_i = 8'h00;
    repeat (16) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    rdc(A_EN, 16'h0000);
    rdc(A_LAT, 16'h0000);
    rdc(A_IDA, 16'h0000);
    rdc(A_EXB, 16'h0000);
    rdc(A_RXB, 16'h0000);
    rdc(A_IDA, 16'h0101);
    irqc(1'b0);
    $display("test 1 done");
    apb(1'b1, A_IDA, 16'h0000);
    for (k = 0; k < 16; k++)
      apb(1'b1, A_EXB, 16'h00a0 + k[15:0]);
    rdc(A_IDA, 16'h0000);
    for (k = 0; k < 16; k++)
      rdc(A_EXB, 16'h00a0 + k[15:0]);
    rdc(A_LIV, 16'h0004);
    rdc(A_LAT, 16'h0004);
    apb(1'b1, A_LAT, 16'h0000);
    rdc(A_LAT, 16'h0004);
    apb(1'b1, A_LAT, 16'h0004);
    rdc(A_LAT, 16'h0000);
    $display("test 2 done");
    send_id(8'ha0);
    send_id(8'ha0);
    rdc(A_LIV, 16'h0000);
    rdc(A_LAT, 16'h0008);
    for (k = 0; k < 16; k++)
      rdc(A_RXB, 16'h00a0 + k[15:0]);
    rdc(A_IDA, 16'h0000);
    apb(1'b1, A_LAT, 16'h000f);
    send_id(8'h10);
    send_id(8'h10);
    rdc(A_LAT, 16'h000c);
    apb(1'b1, A_LAT, 16'h000f);
    $display("test 3 done");
    for (k = 0; k < 7; k++)
      send_id(8'h20 + k[7:0]);
    rdc(A_LIV, 16'h0004);
    send_id(8'h27);
    rdc(A_LIV, 16'h0006);
    rdc(A_LAT, 16'h0002);
    apb(1'b1, A_LAT, 16'h000f);
    $display("test 4 done");
    for (k = 0; k < 4; k++)
      send_id(8'h00);
    rdc(A_LIV, 16'h0004);
    send_id(8'h00);
    rdc(A_LIV, 16'h0005);
    rdc(A_LAT, 16'h0009);
    $display("test 5 done");
    apb(1'b1, A_LAT, 16'h0008);
    irqc(1'b0);
    apb(1'b1, A_EN, 16'h0001);
    irqc(1'b1);
    @(posedge clk_sys_i);
    port_summary_irq_en_i <= 1'b0;
    irqc(1'b0);
    @(posedge clk_sys_i);
    port_summary_irq_en_i <= 1'b1;
    apb(1'b1, A_EN, 16'h000e);
    irqc(1'b0);
    rdc(A_EN, 16'h000e);
    apb(1'b1, A_EN, 16'h0001);
    apb(1'b1, A_LAT, 16'h0001);
    irqc(1'b0);
    rdc(A_LAT, 16'h0000);
    $display("test 6 done");
    apb(1'b0, 12'h3e8, 16'h0000);
    `CHK(err, 1'b1)
    `CHK(rd, 32'h0000_0000)
    apb(1'b1, A_RXB, 16'h00ff);
    apb(1'b1, A_IDA, 16'h0f0f);
    rdc(A_EXB, 16'h00af);
    rdc(A_RXB, 16'h0000);
    rdc(A_IDA, 16'h0000);
    $display("test 7 done");
    apb(1'b1, A_IDA, 16'h0505);
    @(posedge clk_sys_i);
    reset_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    rdc(A_EN, 16'h0000);
    rdc(A_IDA, 16'h0000);
    rdc(A_EXB, 16'h0000);
    rdc(A_LIV, 16'h0000);
    irqc(1'b0);
    $display("test 8 done");
    end_of_test;
  end
endmodule // testbench
